// File: tb.sv
// self-checking bench for the uart status block
`timescale 1ns/1ps
module tb;
   import usif_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0, rd_i = 1'b0, rd_p = 1'b0;
   logic [7:0] rdata_o, m, r;
   logic [3:0] mode_i = USIF_M_ASYNC8;
   logic [1:0] stop_sel = 2'h0;
   logic [11:0] pl = 12'h000;
   logic shf = 1'b0, txfe = 1'b1, txff = 1'b0, rxfe = 1'b1, rxff = 1'b0, par = 1'b0;
   logic frm = 1'b0, busy = 1'b0, flow = 1'b1, mbusy = 1'b0, p1p = 1'b0;
   logic [8:0] p2 = 9'h005;
   logic rx, tick, txfl, rxfl, rxint, uint, eint;
   logic [7:0] exp_q[$];
   logic [7:0] evb[5] = '{8'h20, 8'h10, 8'h01, 8'h02, 8'h10};
   logic [3:0] wmode[5] = '{USIF_M_ASYNC8, USIF_M_LIN_SLV, USIF_M_LIN_MST, USIF_M_ADDR,
      USIF_M_ASYNC8};
   logic [11:0] sb[3] = '{12'h200, 12'h800, 12'h400};
   int failures = 0, checks = 0, cyc = 0, nrx = 0, nfl = 0, n;

   always #10 clock_i = ~clock_i;

   usif_node #(.TICK(8)) i_usif_node (.clock_i(clock_i), .rx_o(rx), .tick_o(tick));

   usif_status #(.FIRST_INSTANCE(1'b1)) i_usif_status (.clock_i(clock_i), .rstn_i(rstn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .mode_i(mode_i), .stop_bits_select_i(stop_sel), .rx_i(rx), .bit_tick_i(tick),
      .tx_shifting_i(shf), .tx_last_stop_i(pl[7]), .tx_fifo_empty_i(txfe),
      .tx_fifo_full_i(txff), .rx_fifo_empty_i(rxfe), .rx_fifo_full_i(rxff),
      .rx_head_parity_i(par), .rx_head_frame_i(frm), .rx_char_done_i(pl[3]), .rx_busy_i(busy),
      .rx_mid_stop1_i(pl[9]), .rx_end_stop1_i(pl[10]), .rx_end_last_stop_i(pl[11]),
      .abd_overflow_i(pl[0]), .abd_done_i(pl[5]), .checksum_bad_i(pl[1]), .dali_stop_i(pl[4]),
      .tx_readback_bad_i(pl[2]), .flow_permit_i(flow), .master_busy_i(mbusy),
      .p1l_pending_i(p1p), .param_two_i(p2), .txb_wr_i(pl[6]), .p1l_wr_i(pl[8]),
      .tx_flush_o(txfl), .rx_flush_o(rxfl), .rx_interrupt_o(rxint), .uart_interrupt_o(uint),
      .err_interrupt_o(eint));

   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", s, e, g);
         failures++;
      end
   endtask

   // register write, one strobe cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   // register read; the expectation waits in the queue for the data cycle
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      repeat (2) @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(e);
      @(posedge clock_i);
      rd_i <= 0;
   endtask

   // one-cycle event pulses, then let flags settle
   task automatic pulse(input logic [11:0] p);
      @(posedge clock_i);
      pl <= p;
      @(posedge clock_i);
      pl <= 12'h000;
      repeat (4) @(posedge clock_i);
   endtask

   // read data watcher, pulse counters and hang limit
   always @(posedge clock_i)
   begin
      rd_p <= rd_i;
      nrx <= nrx + int'(rxint);
      nfl <= nfl + int'(txfl) + int'(rxfl);
      cyc <= cyc + 1;
      if (rd_p && exp_q.size() > 0)
         chk("rdata_o", exp_q.pop_front(), rdata_o);
      if (cyc == 20000)
      begin
         failures++;
         conclude();
      end
   end

   initial
   begin
      void'($urandom(37084));
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rd(OFS_ERR_FLAGS, RST_ERR_FLAGS);
      rd(OFS_ERR_EN, RST_ERR_EN);
      rd(OFS_GEN_INT, RST_GEN_INT);
      rd(OFS_BUF_STAT, 8'h2e);
      rd(3'h6, 8'h00);
      // random buffer levels show live
      repeat (4)
      begin
         r = 8'($urandom);
         {txfe, txff, busy, flow, rxfe, rxff} <= r[5:0];
         rd(OFS_BUF_STAT, {2'b00, r[5:4], ~r[3], r[2:0]});
      end
      {txfe, txff, busy, flow, rxfe, rxff} <= 6'b100110;
      // head byte parity and framing
      rxfe <= 1'b0;
      par <= 1'b1;
      frm <= 1'b1;
      rd(OFS_ERR_FLAGS, 8'hc8);
      r = 8'($urandom);
      {par, frm} <= r[1:0];
      rd(OFS_ERR_FLAGS, {1'b1, r[1], 2'b00, r[0], 3'b000});
      rxfe <= 1'b1;
      rd(OFS_ERR_FLAGS, 8'h80);
      shf <= 1'b1;
      rd(OFS_ERR_FLAGS, 8'h00);
      shf <= 1'b0;
      pulse(12'h080);
      rd(OFS_ERR_FLAGS, 8'h80);
      // error events against random enable masks
      for (int i = 0; i < 5; i++)
      begin
         rxff <= (i == 3);
         mode_i <= (i == 4) ? USIF_M_DALI_DEV : USIF_M_ASYNC8;
         pulse(12'(1 << i));
         m = 8'($urandom);
         wr(OFS_ERR_EN, m);
         rd(OFS_ERR_EN, m);
         rd(OFS_ERR_FLAGS, 8'h80 | evb[i]);
         chk("err_interrupt_o", {7'h0, |(m & (8'h80 | evb[i]))}, {7'h0, eint});
         wr(OFS_ERR_FLAGS, 8'h00);
      end
      rxff <= 1'b0;
      // write error causes per mode; the last write is legal
      for (int i = 0; i < 5; i++)
      begin
         mode_i <= wmode[i];
         txff <= (i == 0);
         p2 <= (i == 1) ? 9'h000 : 9'h005;
         mbusy <= (i == 2);
         p1p <= (i == 3);
         pulse((i == 2 || i == 3) ? 12'h100 : 12'h040);
         rd(OFS_BUF_STAT, {(i != 4), 2'b01, (i == 0), 4'b1110});
         wr(OFS_BUF_STAT, 8'h00);
      end
      {txff, mbusy, p1p} <= 3'b000;
      mode_i <= USIF_M_ASYNC8;
      // flush pulses only on writing ones
      wr(OFS_BUF_STAT, 8'h22);
      wr(OFS_BUF_STAT, 8'h00);
      chk("flush_pulses", 8'h02, 8'(nfl));
      // receive interrupt source per stop detect timing
      for (int c = 0; c < 3; c++)
      begin
         stop_sel <= (c == 2) ? 2'b11 : 2'($urandom % 3);
         wr(OFS_BUF_STAT, (c == 0) ? 8'h00 : 8'h40);
         n = nrx;
         pulse(12'he00 & ~sb[c]);
         pulse(sb[c]);
         chk("rx_interrupt_o", 8'(n + 1), 8'(nrx));
      end
      wr(OFS_BUF_STAT, 8'h00);
      // break length and flag timing
      wr(OFS_CTRL, 8'h08);
      i_usif_node.hold_low(10);
      rd(OFS_ERR_FLAGS, 8'h80);
      fork
         i_usif_node.hold_low(14);
      join_none
      repeat (104) @(posedge clock_i);
      rd(OFS_ERR_FLAGS, 8'h84);
      repeat (16) @(posedge clock_i);
      wr(OFS_ERR_FLAGS, 8'h00);
      wr(OFS_CTRL, 8'h00);
      fork
         i_usif_node.hold_low(14);
      join_none
      repeat (104) @(posedge clock_i);
      rd(OFS_ERR_FLAGS, 8'h80);
      repeat (16) @(posedge clock_i);
      rd(OFS_ERR_FLAGS, 8'h84);
      wr(OFS_ERR_FLAGS, 8'h00);
      mode_i <= USIF_M_DMX;
      i_usif_node.hold_low(20);
      rd(OFS_ERR_FLAGS, 8'h80);
      // mask all error sources so only wake and autobaud reach the interrupt
      wr(OFS_ERR_EN, 8'h00);
      // wake on receive activity
      wr(OFS_CTRL, 8'h10);
      i_usif_node.hold_low(1);
      rd(OFS_GEN_INT, 8'h80);
      rd(OFS_CTRL, 8'h00);
      chk("uart_interrupt_o", 8'h01, {7'h0, uint});
      wr(OFS_GEN_INT, 8'h00);
      rd(OFS_GEN_INT, 8'h00);
      chk("uart_interrupt_o", 8'h00, {7'h0, uint});
      // autobaud done, gated by its enable
      pulse(12'h020);
      rd(OFS_GEN_INT, 8'h40);
      chk("uart_interrupt_o", 8'h00, {7'h0, uint});
      wr(OFS_GEN_INT, 8'h44);
      rd(OFS_GEN_INT, 8'h44);
      chk("uart_interrupt_o", 8'h01, {7'h0, uint});
      // LIN slave byte budget counted since the last break
      mode_i <= USIF_M_LIN_SLV;
      n = 1 + int'($urandom % 4);
      p2 <= 9'(n);
      repeat (n) pulse(12'h040);
      rd(OFS_BUF_STAT, 8'h2e);
      pulse(12'h040);
      rd(OFS_BUF_STAT, 8'hae);
      repeat (3) @(posedge clock_i);
      conclude();
   end
endmodule

// File: usif_node.sv
// remote serial node model: drives the receive line and the bit period ticks
`timescale 1ns/1ps
module usif_node
#(
   parameter int TICK = 8
)
(
   input wire logic clock_i,
   output logic rx_o,
   output logic tick_o
);
   int cnt = 0;
   // line rests at mark (high) outside frames
   initial
   begin
      rx_o = 1'b1;
      tick_o = 1'b0;
   end
   // one tick per bit period
   always @(posedge clock_i)
   begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      tick_o <= (cnt == TICK - 1);
   end
   // hold space for n bit periods, then back to mark
   task automatic hold_low(input int n);
      @(posedge clock_i);
      rx_o <= 1'b0;
      repeat (n * TICK) @(posedge clock_i);
      rx_o <= 1'b1;
   endtask
endmodule

// File: usif_pkg.sv
// package of register map, field positions, reset values and modes for the uart status block
package usif_pkg;
   // register offsets on the plain register port
   localparam logic [2:0] OFS_ERR_FLAGS = 3'h0;
   localparam logic [2:0] OFS_ERR_EN = 3'h1;
   localparam logic [2:0] OFS_GEN_INT = 3'h2;
   localparam logic [2:0] OFS_BUF_STAT = 3'h3;
   localparam logic [2:0] OFS_CTRL = 3'h4;
   // error flag and enable field positions
   localparam int B_TXMT = 7;
   localparam int B_PER = 6;
   localparam int B_ABDOV = 5;
   localparam int B_CER = 4;
   localparam int B_FER = 3;
   localparam int B_BRK = 2;
   localparam int B_RXFO = 1;
   localparam int B_TXC = 0;
   // general interrupt register fields
   localparam int B_WAKE = 7;
   localparam int B_ABD = 6;
   localparam int B_ABD_EN = 2;
   // buffer status fields
   localparam int B_TX_WR_ERR = 7;
   localparam int B_STOP_TIMING = 6;
   localparam int B_TX_EMPTY = 5;
   localparam int B_TX_FULL = 4;
   localparam int B_RX_IDLE = 3;
   localparam int B_FLOW = 2;
   localparam int B_RX_EMPTY = 1;
   localparam int B_RX_FULL = 0;
   // control register fields
   localparam int B_WAKE_EN = 4;
   localparam int B_BRKMD = 3;
   // reset values
   localparam logic [7:0] RST_ERR_FLAGS = 8'h80;
   localparam logic [7:0] RST_ERR_EN = 8'h00;
   localparam logic [7:0] RST_GEN_INT = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   // break lengths in bit periods
   localparam logic [4:0] BRK_BITS_ASYNC = 5'h0b;
   localparam logic [4:0] BRK_BITS_DMX = 5'h17;
   // mode field codes
   typedef enum logic [3:0]
   {
      USIF_M_ASYNC8 = 4'b0000,
      USIF_M_ASYNC7 = 4'b0001,
      USIF_M_ODD = 4'b0010,
      USIF_M_EVEN = 4'b0011,
      USIF_M_ADDR = 4'b0100,
      USIF_M_DALI_DEV = 4'b1000,
      USIF_M_DALI_GEAR = 4'b1001,
      USIF_M_DMX = 4'b1010,
      USIF_M_LIN_SLV = 4'b1011,
      USIF_M_LIN_MST = 4'b1100
   } usif_mode_t;
   // break detector states
   typedef enum logic [1:0]
   {
      USIF_BK_IDLE = 2'b00,
      USIF_BK_COUNT = 2'b01,
      USIF_BK_HELD = 2'b10
   } usif_brk_t;
endpackage

// File: usif_status.sv
// uart status, error flags, interrupt enables and buffer status logic
//
// Behaviour
// RL1: shift-empty flag set after last stop bit, clear while shifting, resets to one.
// RL2: parity flag reflects head byte: parity, DALI forward frame, or address.
// RL3: autobaud overflow set on DALI start measure or baud generator overflow.
// RL4: checksum flag set on DALI stop bit, else on checksum mismatch.
// RL5: framing flag equals head byte framing error.
// RL6: break flag set when break detected, clear otherwise; the code holds it set until software writes a zero to it.
// RL7: overflow flag set when character arrives with receive FIFO full.
// RL8: collision flag set on readback mismatch, first instance only.
// RL9: eight enables gate matching error flags onto interrupt; reset to zero.
// RL10: wake enabled plus line activity sets wake flag until software clears.
// RL11: autobaud done flag sticky; drives interrupt only with its enable.
// RL12: transmit buffer write while output FIFO full sets sticky write error.
// RL13: LIN master: param one low write during master process sets write error.
// RL14: LIN slave: write with param two zero or too many bytes sets error.
// RL15: address mode: param one low rewrite before transfer sets write error.
// RL16: receive interrupt timing follows stop detect timing and stop bits select.
// RL17: tx empty reads buffer empty; writing one flushes; cannot be cleared.
// RL18: tx full and rx full mirror buffer full, hardware only.
// RL19: rx line idle reads one when pin idle, zero while receiving.
// RL20: tx flow permit reflects software flow control, resets to one.
// RL21: rx empty reads buffer empty; writing one flushes; cannot be cleared.
// RL22: break is 11 bit periods low, 23 in DMX mode.
// RL23: break flag timing one sets at minimum time, zero at line release.
// RL24: error interrupt is OR of each flag ANDed with its enable.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module usif_status
   import usif_pkg::*;
#(
   parameter bit FIRST_INSTANCE = 1'b1
)
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [3:0] mode_i,
   input wire logic [1:0] stop_bits_select_i,
   input wire logic rx_i,
   input wire logic bit_tick_i,
   input wire logic tx_shifting_i,
   input wire logic tx_last_stop_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_fifo_full_i,
   input wire logic rx_fifo_empty_i,
   input wire logic rx_fifo_full_i,
   input wire logic rx_head_parity_i,
   input wire logic rx_head_frame_i,
   input wire logic rx_char_done_i,
   input wire logic rx_busy_i,
   input wire logic rx_mid_stop1_i,
   input wire logic rx_end_stop1_i,
   input wire logic rx_end_last_stop_i,
   input wire logic abd_overflow_i,
   input wire logic abd_done_i,
   input wire logic checksum_bad_i,
   input wire logic dali_stop_i,
   input wire logic tx_readback_bad_i,
   input wire logic flow_permit_i,
   input wire logic master_busy_i,
   input wire logic p1l_pending_i,
   input wire logic [8:0] param_two_i,
   input wire logic txb_wr_i,
   input wire logic p1l_wr_i,
   output logic tx_flush_o,
   output logic rx_flush_o,
   output logic rx_interrupt_o,
   output logic uart_interrupt_o,
   output logic err_interrupt_o
);
   logic rst_s1_q;
   logic rst_n;
   // reset release through two flip-flops
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   function automatic logic is_dali(input logic [3:0] m);
      is_dali = (m == USIF_M_DALI_DEV) || (m == USIF_M_DALI_GEAR);
   endfunction

   logic [7:0] err_q, err_d, en_q, en_d, ctrl_q, ctrl_d;
   logic wake_q, wake_d, abd_q, abd_d, abd_en_q, abd_en_d;
   logic wr_err_q, wr_err_d, stop_timing_q, stop_timing_d;
   logic [7:0] rdata_d;
   logic txf_d, rxf_d, rxi_d, ui_d, ei_d;
   logic rx_q, brk_set;
   usif_brk_t bk_q, bk_d;
   logic [4:0] bk_cnt_q, bk_cnt_d;
   logic [8:0] lin_cnt_q, lin_cnt_d;
   logic w_err, w_en, w_gen, w_buf, w_ctl;

   assign w_err = wr_i && (addr_i == OFS_ERR_FLAGS);
   assign w_en = wr_i && (addr_i == OFS_ERR_EN);
   assign w_gen = wr_i && (addr_i == OFS_GEN_INT);
   assign w_buf = wr_i && (addr_i == OFS_BUF_STAT);
   assign w_ctl = wr_i && (addr_i == OFS_CTRL);

   // break detector: count low bit periods, flag by timing mode
   always_comb
   begin
      bk_d = bk_q;
      bk_cnt_d = bk_cnt_q;
      brk_set = 1'b0;
      case (bk_q)
         USIF_BK_IDLE:
         begin
            bk_cnt_d = 5'h00;
            if (!rx_i)
               bk_d = USIF_BK_COUNT;
         end
         USIF_BK_COUNT:
         begin
            if (rx_i)
               bk_d = USIF_BK_IDLE;
            else if (bit_tick_i)
            begin
               bk_cnt_d = bk_cnt_q + 5'h01;
               if (bk_cnt_d == ((mode_i == USIF_M_DMX) ? BRK_BITS_DMX : BRK_BITS_ASYNC)) // [RL22]
               begin
                  bk_d = USIF_BK_HELD;
                  brk_set = ctrl_q[B_BRKMD]; // [RL23]
               end
            end
         end
         USIF_BK_HELD:
         begin
            if (rx_i)
            begin
               bk_d = USIF_BK_IDLE;
               brk_set = !ctrl_q[B_BRKMD]; // [RL23]
            end
         end
         default:
            bk_d = USIF_BK_IDLE;
      endcase
   end

   // flag next values; hardware set wins over software clear
   always_comb
   begin
      err_d = err_q;
      if (w_err)
         err_d = err_q & wdata_i;
      err_d[B_TXMT] = !tx_shifting_i && (tx_last_stop_i || err_q[B_TXMT]); // [RL1]
      err_d[B_PER] = !rx_fifo_empty_i && rx_head_parity_i; // [RL2]
      if (is_dali(mode_i) ? abd_overflow_i : abd_overflow_i)
         err_d[B_ABDOV] = 1'b1; // [RL3]
      if (is_dali(mode_i) ? dali_stop_i : checksum_bad_i)
         err_d[B_CER] = 1'b1; // [RL4]
      err_d[B_FER] = !rx_fifo_empty_i && rx_head_frame_i; // [RL5]
      if (brk_set)
         err_d[B_BRK] = 1'b1; // [RL6]
      if (rx_char_done_i && rx_fifo_full_i)
         err_d[B_RXFO] = 1'b1; // [RL7]
      if (FIRST_INSTANCE && tx_readback_bad_i)
         err_d[B_TXC] = 1'b1; // [RL8]
      else if (!FIRST_INSTANCE)
         err_d[B_TXC] = 1'b0;
      en_d = w_en ? wdata_i : en_q; // [RL9]
      ctrl_d = w_ctl ? (wdata_i & 8'h18) : ctrl_q;
      wake_d = (w_gen ? wdata_i[B_WAKE] & wake_q : wake_q)
         | (ctrl_q[B_WAKE_EN] && rx_q && !rx_i); // [RL10]
      if (ctrl_q[B_WAKE_EN] && rx_q && !rx_i)
         ctrl_d[B_WAKE_EN] = 1'b0;
      abd_d = (w_gen ? wdata_i[B_ABD] & abd_q : abd_q) | abd_done_i; // [RL11]
      abd_en_d = w_gen ? wdata_i[B_ABD_EN] : abd_en_q;
      stop_timing_d = w_buf ? wdata_i[B_STOP_TIMING] : stop_timing_q;
      wr_err_d = w_buf ? (wdata_i[B_TX_WR_ERR] & wr_err_q) : wr_err_q;
      if (txb_wr_i && tx_fifo_full_i)
         wr_err_d = 1'b1; // [RL12]
      if (mode_i == USIF_M_LIN_MST && p1l_wr_i && master_busy_i)
         wr_err_d = 1'b1; // [RL13]
      if ((mode_i == USIF_M_LIN_SLV) && txb_wr_i
          && ((param_two_i == 9'h000) || (lin_cnt_q >= param_two_i)))
         wr_err_d = 1'b1; // [RL14]
      if (mode_i == USIF_M_ADDR && p1l_wr_i && p1l_pending_i)
         wr_err_d = 1'b1; // [RL15]
      lin_cnt_d = lin_cnt_q;
      if (brk_set || bk_q == USIF_BK_HELD)
         lin_cnt_d = 9'h000;
      else if (txb_wr_i && lin_cnt_q != 9'h1ff)
         lin_cnt_d = lin_cnt_q + 9'h001;
   end

   // outputs, read data and flush strobes
   always_comb
   begin
      rdata_d = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            OFS_ERR_FLAGS: rdata_d = err_q;
            OFS_ERR_EN: rdata_d = en_q;
            OFS_GEN_INT: rdata_d = {wake_q, abd_q, 3'b000, abd_en_q, 2'b00};
            OFS_BUF_STAT: rdata_d = {wr_err_q, stop_timing_q, tx_fifo_empty_i, // [RL17]
               tx_fifo_full_i, !rx_busy_i, flow_permit_i, // [RL18] [RL19] [RL20]
               rx_fifo_empty_i, rx_fifo_full_i}; // [RL21] [RL18]
            OFS_CTRL: rdata_d = ctrl_q;
            default: rdata_d = 8'h00;
         endcase
      end
      txf_d = w_buf && wdata_i[B_TX_EMPTY]; // [RL17]
      rxf_d = w_buf && wdata_i[B_RX_EMPTY]; // [RL21]
      if (!stop_timing_q)
         rxi_d = rx_mid_stop1_i; // [RL16]
      else if (stop_bits_select_i == 2'b11)
         rxi_d = rx_end_stop1_i; // [RL16]
      else
         rxi_d = rx_end_last_stop_i; // [RL16]
      ei_d = |(err_q & en_q); // [RL24]
      ui_d = ei_d || wake_q || (abd_q && abd_en_q); // [RL10] [RL11]
   end

   // register every group
   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         err_q <= RST_ERR_FLAGS;
         en_q <= RST_ERR_EN;
         ctrl_q <= RST_CTRL;
         wake_q <= 1'b0;
         abd_q <= 1'b0;
         abd_en_q <= 1'b0;
         wr_err_q <= 1'b0;
         stop_timing_q <= 1'b0;
         bk_q <= USIF_BK_IDLE;
         bk_cnt_q <= 5'h00;
         lin_cnt_q <= 9'h000;
         rx_q <= 1'b1;
         rdata_o <= 8'h00;
         tx_flush_o <= 1'b0;
         rx_flush_o <= 1'b0;
         rx_interrupt_o <= 1'b0;
         uart_interrupt_o <= 1'b0;
         err_interrupt_o <= 1'b0;
      end
      else
      begin
         err_q <= err_d;
         en_q <= en_d;
         ctrl_q <= ctrl_d;
         wake_q <= wake_d;
         abd_q <= abd_d;
         abd_en_q <= abd_en_d;
         wr_err_q <= wr_err_d;
         stop_timing_q <= stop_timing_d;
         bk_q <= bk_d;
         bk_cnt_q <= bk_cnt_d;
         lin_cnt_q <= lin_cnt_d;
         rx_q <= rx_i;
         rdata_o <= rdata_d;
         tx_flush_o <= txf_d;
         rx_flush_o <= rxf_d;
         rx_interrupt_o <= rxi_d;
         uart_interrupt_o <= ui_d;
         err_interrupt_o <= ei_d;
      end
   end

   // checks on flag setting, interrupt gating, write errors and break timing
   ovf_set_a: assert property ( // [RL7]
      @(posedge clock_i) disable iff (!rst_n)
      rx_char_done_i && rx_fifo_full_i |=> err_q[B_RXFO])
      else $error("overflow flag not set");
   txmt_clr_a: assert property ( // [RL1]
      @(posedge clock_i) disable iff (!rst_n)
      tx_shifting_i |=> !err_q[B_TXMT])
      else $error("shift empty flag set while shifting");
   txmt_set_a: assert property ( // [RL1]
      @(posedge clock_i) disable iff (!rst_n)
      tx_last_stop_i && !tx_shifting_i |=> err_q[B_TXMT])
      else $error("shift empty flag not set");
   per_head_a: assert property ( // [RL2]
      @(posedge clock_i) disable iff (!rst_n)
      ##1 err_q[B_PER] == $past(!rx_fifo_empty_i && rx_head_parity_i))
      else $error("parity flag mismatch");
   abdov_set_a: assert property ( // [RL3]
      @(posedge clock_i) disable iff (!rst_n)
      abd_overflow_i |=> err_q[B_ABDOV])
      else $error("autobaud overflow not flagged");
   cer_dali_a: assert property ( // [RL4]
      @(posedge clock_i) disable iff (!rst_n)
      is_dali(mode_i) && dali_stop_i |=> err_q[B_CER])
      else $error("stop bit flag not set");
   cer_sum_a: assert property ( // [RL4]
      @(posedge clock_i) disable iff (!rst_n)
      !is_dali(mode_i) && checksum_bad_i |=> err_q[B_CER])
      else $error("checksum flag not set");
   fer_head_a: assert property ( // [RL5]
      @(posedge clock_i) disable iff (!rst_n)
      ##1 err_q[B_FER] == $past(!rx_fifo_empty_i && rx_head_frame_i))
      else $error("framing flag mismatch");
   brk_set_a: assert property ( // [RL6]
      @(posedge clock_i) disable iff (!rst_n)
      brk_set |=> err_q[B_BRK])
      else $error("break flag not set");
   txc_set_a: assert property ( // [RL8]
      @(posedge clock_i) disable iff (!rst_n)
      tx_readback_bad_i |=> err_q[B_TXC] == FIRST_INSTANCE)
      else $error("collision flag wrong");
   err_irq_a: assert property ( // [RL24]
      @(posedge clock_i) disable iff (!rst_n)
      (|(err_q & en_q)) |=> err_interrupt_o)
      else $error("error interrupt missing");
   irq_gate_a: assert property ( // [RL9]
      @(posedge clock_i) disable iff (!rst_n)
      (en_q == 8'h00) |=> !err_interrupt_o)
      else $error("masked flag raised interrupt");
   en_reg_a: assert property ( // [RL9]
      @(posedge clock_i) disable iff (!rst_n)
      w_en |=> en_q == $past(wdata_i))
      else $error("enable write lost");
   full_wr_a: assert property ( // [RL12]
      @(posedge clock_i) disable iff (!rst_n)
      txb_wr_i && tx_fifo_full_i |=> wr_err_q
         ##1 (wr_err_q || $past(w_buf && !wdata_i[B_TX_WR_ERR])))
      else $error("write error not sticky");
   lin_mst_a: assert property ( // [RL13]
      @(posedge clock_i) disable iff (!rst_n)
      mode_i == USIF_M_LIN_MST && p1l_wr_i && master_busy_i |=> wr_err_q)
      else $error("master write error missing");
   lin_slv_a: assert property ( // [RL14]
      @(posedge clock_i) disable iff (!rst_n)
      mode_i == USIF_M_LIN_SLV && txb_wr_i && param_two_i == 9'h000 |=> wr_err_q)
      else $error("slave write error missing");
   addr_p1_a: assert property ( // [RL15]
      @(posedge clock_i) disable iff (!rst_n)
      mode_i == USIF_M_ADDR && p1l_wr_i && p1l_pending_i |=> wr_err_q)
      else $error("address write error missing");
   rxi_mid_a: assert property ( // [RL16]
      @(posedge clock_i) disable iff (!rst_n)
      !stop_timing_q && rx_mid_stop1_i |=> rx_interrupt_o)
      else $error("receive interrupt missing");
   brk_len_a: assert property ( // [RL22]
      @(posedge clock_i) disable iff (!rst_n)
      $rose(bk_q == USIF_BK_HELD) |->
         bk_cnt_q == (($past(mode_i) == USIF_M_DMX) ? BRK_BITS_DMX : BRK_BITS_ASYNC))
      else $error("break length wrong");
   brk_rel_a: assert property ( // [RL23]
      @(posedge clock_i) disable iff (!rst_n)
      bk_q == USIF_BK_HELD && rx_i && !ctrl_q[B_BRKMD] |=> err_q[B_BRK])
      else $error("break not flagged at release");
   wake_set_a: assert property ( // [RL10]
      @(posedge clock_i) disable iff (!rst_n)
      ctrl_q[B_WAKE_EN] && rx_q && !rx_i |=> wake_q ##1 uart_interrupt_o)
      else $error("wake not flagged");
   wake_irq_a: assert property ( // [RL10]
      @(posedge clock_i) disable iff (!rst_n)
      wake_q |=> uart_interrupt_o)
      else $error("wake interrupt missing");
   abd_sticky_a: assert property ( // [RL11]
      @(posedge clock_i) disable iff (!rst_n)
      abd_q && !w_gen |=> abd_q)
      else $error("autobaud done lost");
   rx_flush_a: assert property ( // [RL21]
      @(posedge clock_i) disable iff (!rst_n)
      w_buf && wdata_i[B_RX_EMPTY] |=> rx_flush_o)
      else $error("receive flush missing");
   tx_flush_a: assert property ( // [RL17]
      @(posedge clock_i) disable iff (!rst_n)
      w_buf && wdata_i[B_TX_EMPTY] |=> tx_flush_o)
      else $error("transmit flush missing");
endmodule
